// >>> rtl/ds_retention_defines.svh
`ifndef DS_RETENTION_DEFINES_SVH
`define DS_RETENTION_DEFINES_SVH

// Widths.
`define DSR_PIN_COUNT 16
`define DSR_REG_W 16
`define DSR_ADDR_W 8
`define DSR_WDT_W 37

// Register byte addresses.
`define DSR_OFF_RESET_CAUSE 8'h00
`define DSR_OFF_DS_CONTROL 8'h04
`define DSR_OFF_WAKE_SOURCE 8'h08
`define DSR_OFF_SCRATCH_0 8'h0c
`define DSR_OFF_SCRATCH_1 8'h10
`define DSR_OFF_PIN_DIRECTION 8'h14
`define DSR_OFF_OUTPUT_LATCH 8'h18
`define DSR_OFF_POWER_STATUS 8'h1c

// Reset-cause fields and values.
`define DSR_RC_POR_BIT 0
`define DSR_RC_BOR_BIT 1
`define DSR_RC_EXTR_BIT 7
`define DSR_RC_DEEP_SLEEP_FLAG_BIT 10
`define DSR_RC_MASK 16'he5ff
`define DSR_RC_POR_VALUE 16'h0003

// Deep-sleep control fields.
`define DSR_DC_HOLD_BIT 0
`define DSR_DC_BROWNOUT_BIT 1
`define DSR_DC_ARM_BIT 15

// Wake-source fields and values.
`define DSR_WS_POR_BIT 0
`define DSR_WS_MASTER_CLEAR_PIN_BIT 2
`define DSR_WS_CAL_BIT 3
`define DSR_WS_WDT_BIT 4
`define DSR_WS_FAULT_BIT 7
`define DSR_WS_EXT_BIT 8
`define DSR_WS_MASK 16'h019d
`define DSR_WS_POR_VALUE 16'h0001

// Pin reset state: all inputs, latches low.
`define DSR_DIR_RESET 16'hffff
`define DSR_LAT_RESET 16'h0000

// Arm bit lives two instruction cycles, one clock each.
`define DSR_ARM_LIFE 2'h2

// Watchdog time-out is 2^(base + step * postscale) reference ticks.
`define DSR_WDT_EXP_BASE 6'h06

// Bus answers.
`define DSR_RESP_OKAY 2'h0
`define DSR_RESP_SLVERR 2'h2

`endif

// >>> rtl/ds_retention_pkg.sv
`include "ds_retention_defines.svh"

package ds_retention_pkg;

    // Gray path: active -> deep sleep -> wake reset; the return to active flips both bits.
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_DEEP = 2'b01,
        ST_WAKE = 2'b11
    } ds_state_t;

    typedef struct packed {
        logic brownout_en;
        logic wdt_en;
        logic [3:0] wdt_postscale;
        logic wdt_clk_secondary_osc;
        logic cal_clk_secondary_osc;
    } ds_config_t;

    typedef struct packed {
        logic ext_int;
        logic master_clear;
        logic calendar_alarm;
        logic brownout;
        logic fault;
    } wake_events_t;

    typedef struct packed {
        logic [`DSR_PIN_COUNT-1:0] level;
        logic [`DSR_PIN_COUNT-1:0] oe;
    } pin_drive_t;

endpackage

// >>> rtl/deep_sleep_retention_control.sv
`timescale 1ns/100ps
`include "ds_retention_defines.svh"

// Behaviour
// - Pins that were inputs at deep-sleep entry stay undriven throughout deep sleep.
// - Pins that were outputs keep driving their latch level captured at entry.
// - After wake, direction and latch reset; pins stay held while hold bit set.
// - Clearing the hold bit makes pins follow current direction and latch at once.
// - Enabled brown-out or power cycle releases pins and wipes both scratch words.
// - Master clear in deep sleep releases pins but keeps scratch words.
// - Watchdog time-out is set by a four-bit postscale field.
// - A configuration bit picks the watchdog clock: low-power RC or secondary.
// - Enable bit runs the watchdog; its counter clears on every deep-sleep entry.
// - Enabled watchdog starts its clock itself; counting may start late.
// - Deep-sleep brown-out sets control bit 1 and clears hold bit 0; it never wakes.
// - Calendar keeps running from selected oscillator; its alarm wakes the device.
// - Sleep instruction enters deep sleep if arm bit 15 set, else ordinary sleep.
// - Hardware clears the arm bit on wake-up.
// - Reset-cause bit 10 reads one after deep sleep occurred.
// - Software sets or clears any reset-cause flag without causing a reset.
// - Power-on sets reset-cause brown-out bit 1 and power-on bit 0.
// - Wake-source flags: bits 8, 7, 4, 3, 2, 0 set by their causes.
// - Wake-source power-on flag may be set outside deep sleep.
// - Scratch words survive deep sleep; only power-on or enabled deep-sleep brown-out clears.
// - Arm bit clears itself two instruction cycles after being set.
// - Wake generates internal power-on reset; flags and scratch are retained.
module deep_sleep_retention_control (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [`DSR_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`DSR_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire ds_retention_pkg::ds_config_t cfg,
    input wire ds_retention_pkg::wake_events_t events,
    input wire logic power_save_instruction,
    input wire logic low_power_rc_osc_tick,
    input wire logic secondary_osc_tick,
    output ds_retention_pkg::pin_drive_t pins,
    output logic low_power_rc_osc_enable,
    output logic secondary_osc_enable,
    output logic calendar_tick,
    output logic internal_por,
    output logic sleep_entered,
    output logic deep_sleep_active
);

    ds_retention_pkg::ds_state_t state;
    ds_retention_pkg::ds_state_t next_state;
    logic [`DSR_REG_W-1:0] reset_cause_control;
    logic [`DSR_REG_W-1:0] deep_sleep_wake_source;
    logic [`DSR_REG_W-1:0] persistent_scratch_0;
    logic [`DSR_REG_W-1:0] persistent_scratch_1;
    logic deep_sleep_arm;
    logic [1:0] arm_age;
    logic deep_sleep_brownout;
    logic pin_hold;
    logic [`DSR_PIN_COUNT-1:0] pin_direction;
    logic [`DSR_PIN_COUNT-1:0] output_latch;
    logic [`DSR_PIN_COUNT-1:0] held_direction;
    logic [`DSR_PIN_COUNT-1:0] held_latch;
    logic [`DSR_WDT_W-1:0] wdt_count;
    logic woke_by_master_clear_pin;

    // Operating-state decode.
    wire in_active = (state == ds_retention_pkg::ST_ACTIVE);
    wire in_deep = (state == ds_retention_pkg::ST_DEEP);
    wire in_wake = (state == ds_retention_pkg::ST_WAKE);
    wire enter_deep = in_active & power_save_instruction & deep_sleep_arm;
    wire enter_sleep = in_active & power_save_instruction & ~deep_sleep_arm;
    wire brownout_hit = in_deep & cfg.brownout_en & events.brownout;
    wire master_clear_pin_hit = in_deep & events.master_clear;

    // Watchdog reference and threshold; the tick only counts once the chosen
    // oscillator is actually running, so a cold start simply delays time-out.
    wire wdt_run = in_deep & cfg.wdt_en;
    wire wdt_ref_tick = cfg.wdt_clk_secondary_osc ? secondary_osc_tick : low_power_rc_osc_tick;
    wire [5:0] wdt_exp = {1'b0, cfg.wdt_postscale, 1'b0} + `DSR_WDT_EXP_BASE;
    wire [`DSR_WDT_W-1:0] wdt_limit = {{(`DSR_WDT_W-1){1'b0}}, 1'b1} << wdt_exp;
    wire wdt_timeout = wdt_run & (wdt_count == wdt_limit);
    wire wake_now = in_deep & (events.ext_int | events.calendar_alarm | wdt_timeout
        | events.master_clear);

    // Oscillator requests: calendar always runs, watchdog only in deep sleep.
    assign low_power_rc_osc_enable = (wdt_run & ~cfg.wdt_clk_secondary_osc) | ~cfg.cal_clk_secondary_osc;
    assign secondary_osc_enable = (wdt_run & cfg.wdt_clk_secondary_osc) | cfg.cal_clk_secondary_osc;
    assign calendar_tick = cfg.cal_clk_secondary_osc ? secondary_osc_enable & secondary_osc_tick : low_power_rc_osc_tick;
    assign deep_sleep_active = in_deep;

    // Next state.
    always_comb begin
        case (state)
            ds_retention_pkg::ST_ACTIVE: next_state = enter_deep ?
                ds_retention_pkg::ST_DEEP : ds_retention_pkg::ST_ACTIVE;
            ds_retention_pkg::ST_DEEP: next_state = wake_now ?
                ds_retention_pkg::ST_WAKE : ds_retention_pkg::ST_DEEP;
            ds_retention_pkg::ST_WAKE: next_state = ds_retention_pkg::ST_ACTIVE;
            default: next_state = ds_retention_pkg::ST_ACTIVE;
        endcase
    end

    // State register; the wake state is the one-cycle internal power-on reset.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ds_retention_pkg::ST_ACTIVE;
            internal_por <= 1'b0;
            sleep_entered <= 1'b0;
            woke_by_master_clear_pin <= 1'b0;
        end else begin
            state <= next_state;
            internal_por <= (next_state == ds_retention_pkg::ST_WAKE);
            sleep_entered <= enter_sleep;
            woke_by_master_clear_pin <= master_clear_pin_hit;
        end
    end

    // Write channel: address and data are taken together, one write at a time.
    wire wr_fire = awvalid & wvalid & ~bvalid;
    assign awready = wr_fire;
    assign wready = wr_fire;
    wire wr_rc = wr_fire & (awaddr == `DSR_OFF_RESET_CAUSE);
    wire wr_dc = wr_fire & (awaddr == `DSR_OFF_DS_CONTROL);
    wire wr_ws = wr_fire & (awaddr == `DSR_OFF_WAKE_SOURCE);
    wire wr_s0 = wr_fire & (awaddr == `DSR_OFF_SCRATCH_0);
    wire wr_s1 = wr_fire & (awaddr == `DSR_OFF_SCRATCH_1);
    wire wr_dir = wr_fire & (awaddr == `DSR_OFF_PIN_DIRECTION);
    wire wr_lat = wr_fire & (awaddr == `DSR_OFF_OUTPUT_LATCH);
    wire wr_known = wr_rc | wr_dc | wr_ws | wr_s0 | wr_s1 | wr_dir | wr_lat
        | (awaddr == `DSR_OFF_POWER_STATUS);
    wire [`DSR_REG_W-1:0] wmask = {{8{wstrb[1]}}, {8{wstrb[0]}}};

    // Merges written byte lanes into an old 16-bit value.
    function automatic logic [`DSR_REG_W-1:0] merge(input logic [`DSR_REG_W-1:0] old,
        input logic [`DSR_REG_W-1:0] data, input logic [`DSR_REG_W-1:0] lanes);
        merge = (old & ~lanes) | (data & lanes);
    endfunction

    wire [`DSR_REG_W-1:0] wdata16 = wdata[`DSR_REG_W-1:0];
    wire [`DSR_REG_W-1:0] dc_now = {deep_sleep_arm, 13'h0000, deep_sleep_brownout, pin_hold};
    wire [`DSR_REG_W-1:0] dc_new = merge(dc_now, wdata16, wmask);
    wire arm_write = wr_dc & wstrb[1] & dc_new[`DSR_DC_ARM_BIT];

    // Write response.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bvalid <= 1'b0;
            bresp <= `DSR_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_known ? `DSR_RESP_OKAY : `DSR_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Reset-cause flags survive the wake reset; software writes never reset.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reset_cause_control <= `DSR_RC_POR_VALUE;
        end else begin
            if (wr_rc) begin
                reset_cause_control <= merge(reset_cause_control, wdata16, wmask)
                    & `DSR_RC_MASK;
            end
            if (in_wake) begin
                reset_cause_control[`DSR_RC_DEEP_SLEEP_FLAG_BIT] <= 1'b1;
            end
            if (in_wake & woke_by_master_clear_pin) begin
                reset_cause_control[`DSR_RC_EXTR_BIT] <= 1'b1;
            end
        end
    end

    // Arm bit: self-clears after its short lifetime so a stray sleep later
    // falls into ordinary sleep; it freezes during deep sleep and clears on wake.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            deep_sleep_arm <= 1'b0;
            arm_age <= 2'h0;
        end else if (in_wake) begin
            deep_sleep_arm <= 1'b0;
            arm_age <= 2'h0;
        end else if (arm_write) begin
            deep_sleep_arm <= 1'b1;
            arm_age <= 2'h0;
        end else if (in_active & deep_sleep_arm) begin
            arm_age <= arm_age + 2'h1;
            if (arm_age == `DSR_ARM_LIFE - 2'h1) begin
                deep_sleep_arm <= 1'b0;
            end
        end
    end

    // Brown-out status and pin hold; hardware sets win over a same-cycle write.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            deep_sleep_brownout <= 1'b0;
            pin_hold <= 1'b0;
        end else begin
            if (wr_dc & wstrb[0]) begin
                deep_sleep_brownout <= dc_new[`DSR_DC_BROWNOUT_BIT];
                pin_hold <= dc_new[`DSR_DC_HOLD_BIT];
            end
            if (brownout_hit) begin
                deep_sleep_brownout <= 1'b1;
            end
            if (enter_deep) begin
                pin_hold <= 1'b1;
            end else if (brownout_hit | master_clear_pin_hit) begin
                pin_hold <= 1'b0;
            end
        end
    end

    // Wake sources: cleared on entry, then set by what happens in deep sleep.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            deep_sleep_wake_source <= `DSR_WS_POR_VALUE;
        end else if (enter_deep) begin
            deep_sleep_wake_source <= 16'h0000;
        end else begin
            if (wr_ws) begin
                deep_sleep_wake_source <= merge(deep_sleep_wake_source, wdata16, wmask)
                    & `DSR_WS_MASK;
            end
            if (in_deep & events.ext_int) begin
                deep_sleep_wake_source[`DSR_WS_EXT_BIT] <= 1'b1;
            end
            if (in_deep & events.fault) begin
                deep_sleep_wake_source[`DSR_WS_FAULT_BIT] <= 1'b1;
            end
            if (wdt_timeout) begin
                deep_sleep_wake_source[`DSR_WS_WDT_BIT] <= 1'b1;
            end
            if (in_deep & events.calendar_alarm) begin
                deep_sleep_wake_source[`DSR_WS_CAL_BIT] <= 1'b1;
            end
            if (master_clear_pin_hit) begin
                deep_sleep_wake_source[`DSR_WS_MASTER_CLEAR_PIN_BIT] <= 1'b1;
            end
        end
    end

    // Scratch words: only a power-on or an enabled brown-out wipes them.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            persistent_scratch_0 <= 16'h0000;
            persistent_scratch_1 <= 16'h0000;
        end else if (brownout_hit) begin
            persistent_scratch_0 <= 16'h0000;
            persistent_scratch_1 <= 16'h0000;
        end else begin
            if (wr_s0) begin
                persistent_scratch_0 <= merge(persistent_scratch_0, wdata16, wmask);
            end
            if (wr_s1) begin
                persistent_scratch_1 <= merge(persistent_scratch_1, wdata16, wmask);
            end
        end
    end

    // Direction and latch take power-on values on the wake reset.
    always_ff @(posedge clk) begin
        if (!nrst || in_wake) begin
            pin_direction <= `DSR_DIR_RESET;
            output_latch <= `DSR_LAT_RESET;
        end else begin
            if (wr_dir) begin
                pin_direction <= merge(pin_direction, wdata16, wmask);
            end
            if (wr_lat) begin
                output_latch <= merge(output_latch, wdata16, wmask);
            end
        end
    end

    // Snapshot tracks the live settings while released and freezes on hold.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            held_direction <= `DSR_DIR_RESET;
            held_latch <= `DSR_LAT_RESET;
        end else if (!pin_hold) begin
            held_direction <= pin_direction;
            held_latch <= output_latch;
        end
    end

    // Pin drivers, one slice per pin; while held, register writes never reach them.
    genvar gi;
    generate
        for (gi = 0; gi < `DSR_PIN_COUNT; gi++) begin : g_pin
            wire dir_bit = pin_hold ? held_direction[gi] : pin_direction[gi];
            assign pins.oe[gi] = ~dir_bit;
            assign pins.level[gi] = pin_hold ? held_latch[gi] : output_latch[gi];
        end
    endgenerate

    // Watchdog counter restarts at every entry and counts reference ticks.
    always_ff @(posedge clk) begin
        if (!nrst || enter_deep) begin
            wdt_count <= '0;
        end else if (wdt_run & wdt_ref_tick & ~wdt_timeout) begin
            wdt_count <= wdt_count + {{(`DSR_WDT_W-1){1'b0}}, 1'b1};
        end
    end

    // Read channel: one registered answer, the cycle after the address is taken.
    wire rd_fire = arvalid & ~rvalid;
    assign arready = ~rvalid;
    logic [`DSR_REG_W-1:0] rd_value;
    logic rd_known;
    always_comb begin
        rd_known = 1'b1;
        case (araddr)
            `DSR_OFF_RESET_CAUSE: rd_value = reset_cause_control;
            `DSR_OFF_DS_CONTROL: rd_value = dc_now;
            `DSR_OFF_WAKE_SOURCE: rd_value = deep_sleep_wake_source;
            `DSR_OFF_SCRATCH_0: rd_value = persistent_scratch_0;
            `DSR_OFF_SCRATCH_1: rd_value = persistent_scratch_1;
            `DSR_OFF_PIN_DIRECTION: rd_value = pin_direction;
            `DSR_OFF_OUTPUT_LATCH: rd_value = output_latch;
            `DSR_OFF_POWER_STATUS: rd_value = {14'h0000, state};
            default: begin
                rd_value = 16'h0000;
                rd_known = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `DSR_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid <= 1'b1;
            rdata <= {16'h0000, rd_value};
            rresp <= rd_known ? `DSR_RESP_OKAY : `DSR_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Covers every held pin at once, so any input slice that drives is caught.
    a_input_pins_float: assert property (in_deep && pin_hold
        |-> (pins.oe & held_direction) == '0)
        else $error("Input pin driven during deep sleep.");
    a_output_pins_hold: assert property (in_deep && $stable(state) |-> $stable(pins))
        else $error("Held pin drive changed during deep sleep.");
    a_hold_blocks_writes: assert property (pin_hold && $past(pin_hold) && wr_dir
        |=> pins.oe == ~held_direction)
        else $error("Direction write reached pins while held.");
    a_release_follows: assert property (!pin_hold |-> pins.oe == ~pin_direction
        && pins.level == output_latch)
        else $error("Released pins do not follow registers.");
    a_brownout_release: assert property (brownout_hit |=> !pin_hold
        && persistent_scratch_0 == 16'h0000 && deep_sleep_brownout)
        else $error("Brown-out did not release pins and wipe scratch.");
    // The wake pulse stands in the very cycle after the master-clear event.
    a_master_clear_pin_keeps_scratch: assert property (master_clear_pin_hit && !brownout_hit
        |=> !pin_hold && $stable(persistent_scratch_1) && internal_por)
        else $error("Master clear mishandled in deep sleep.");
    a_brownout_no_wake: assert property (brownout_hit && !wake_now |=> in_deep)
        else $error("Brown-out woke the device.");
    a_arm_lifetime: assert property ($rose(deep_sleep_arm) && in_active
        && !power_save_instruction && !arm_write
        ##1 in_active && !power_save_instruction && !arm_write |=> !deep_sleep_arm)
        else $error("Arm bit outlived two cycles.");
    a_wake_sets_flag: assert property (in_wake |=> !deep_sleep_arm
        && reset_cause_control[`DSR_RC_DEEP_SLEEP_FLAG_BIT] && pin_direction == `DSR_DIR_RESET)
        else $error("Wake did not clear arm or set deep-sleep flag.");
    a_wdt_clears: assert property (enter_deep |=> wdt_count == '0)
        else $error("Watchdog not cleared on entry.");

endmodule

// >>> testbench/wake_source_model.sv
`timescale 1ns/100ps
// Far side of the block: the two low-power oscillators and the wake sources.
module wake_source_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic low_power_rc_osc_on,
    input wire logic secondary_osc_on,
    input wire ds_retention_pkg::wake_events_t fire,
    output ds_retention_pkg::wake_events_t events,
    output logic low_power_rc_osc_tick,
    output logic secondary_osc_tick
);
    logic phase;
    // Ticks come only while the block requests its oscillator, so a block that
    // forgets to start its watchdog clock never sees a tick and never times out.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase <= 1'b0;
            low_power_rc_osc_tick <= 1'b0;
            secondary_osc_tick <= 1'b0;
            events <= '0;
        end else begin
            phase <= ~phase;
            low_power_rc_osc_tick <= low_power_rc_osc_on & phase;
            secondary_osc_tick <= secondary_osc_on & ~phase;
            events <= fire;
        end
    end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/100ps
`include "ds_retention_defines.svh"
module testbench;
    logic clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, psi = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, got;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, resp;
    logic low_power_rc_osc_tick, secondary_osc_tick, low_power_rc_osc_en, secondary_osc_en, cal_tick, por, slp, dsa;
    ds_retention_pkg::ds_config_t cfg = 8'h80;
    ds_retention_pkg::wake_events_t events, fire = 5'h00;
    ds_retention_pkg::pin_drive_t pins;
    int miscompares = 0, total_checks = 0;
    deep_sleep_retention_control i_deep_sleep_retention_control (.clk(clk), .nrst(nrst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .cfg(cfg), .events(events),
        .power_save_instruction(psi), .low_power_rc_osc_tick(low_power_rc_osc_tick), .secondary_osc_tick(secondary_osc_tick),
        .pins(pins), .low_power_rc_osc_enable(low_power_rc_osc_en), .secondary_osc_enable(secondary_osc_en),
        .calendar_tick(cal_tick), .internal_por(por), .sleep_entered(slp),
        .deep_sleep_active(dsa));
    wake_source_model i_wake_source_model (.clk(clk), .nrst(nrst), .low_power_rc_osc_on(low_power_rc_osc_en),
        .secondary_osc_on(secondary_osc_en), .fire(fire), .events(events), .low_power_rc_osc_tick(low_power_rc_osc_tick),
        .secondary_osc_tick(secondary_osc_tick));
    // Free-running 100 MHz clock.
    always #5 clk = ~clk;
    task automatic stop_test();
        if (miscompares == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Address and data go out together; each handshake is judged at a settled negedge.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(negedge clk);
        while (awready !== 1'b1) @(negedge clk);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(negedge clk);
        while (bvalid !== 1'b1) @(negedge clk);
        resp = bresp;
        @(posedge clk);
        chk("bresp", 32'((a > `DSR_OFF_POWER_STATUS) ? `DSR_RESP_SLVERR : `DSR_RESP_OKAY),
            32'(resp));
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] mask, input logic [15:0] exp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge clk);
        while (arready !== 1'b1) @(negedge clk);
        @(posedge clk);
        arvalid <= 1'b0;
        @(negedge clk);
        while (rvalid !== 1'b1) @(negedge clk);
        got = rdata;
        resp = rresp;
        @(posedge clk);
        chk("register", {16'h0000, exp}, got & {16'h0000, mask});
        chk("rresp", 32'((a > `DSR_OFF_POWER_STATUS) ? `DSR_RESP_SLVERR : `DSR_RESP_OKAY),
            32'(resp));
    endtask
    task automatic chkp(input logic [15:0] oe, input logic [15:0] lvl);
        @(negedge clk);
        chk("pins.oe", 32'(oe), 32'(pins.oe));
        chk("pins.level", 32'(lvl), 32'(pins.level & pins.oe));
        @(posedge clk);
    endtask
    // The instruction goes out at once so that it follows an arm write directly.
    task automatic sleep_cmd(input logic deep);
        psi <= 1'b1;
        @(posedge clk);
        psi <= 1'b0;
        @(negedge clk);
        chk("deep_sleep_active", 32'(deep), 32'(dsa));
        chk("sleep_entered", 32'(!deep), 32'(slp));
        @(posedge clk);
    endtask
    task automatic fire_ev(input ds_retention_pkg::wake_events_t f);
        @(posedge clk);
        fire <= f;
        @(posedge clk);
        fire <= 5'h00;
    endtask
    task automatic wake_wait();
        @(negedge clk);
        while (dsa !== 1'b0) @(negedge clk);
        repeat (2) @(posedge clk);
    endtask
    // Sets up pins as upper inputs and lower outputs, then enters deep sleep.
    task automatic go_deep();
        wr(`DSR_OFF_PIN_DIRECTION, 16'hff00);
        wr(`DSR_OFF_OUTPUT_LATCH, 16'h00aa);
        wr(`DSR_OFF_DS_CONTROL, 16'h8000);
        sleep_cmd(1'b1);
    endtask
    // Watchdog: a hang anywhere ends the run as a failure.
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd(`DSR_OFF_RESET_CAUSE, 16'hffff, 16'h0003);
        rd(`DSR_OFF_WAKE_SOURCE, 16'hffff, 16'h0001);
        rd(`DSR_OFF_SCRATCH_0, 16'hffff, 16'h0000);
        wr(`DSR_OFF_RESET_CAUSE, 16'hffff);
        rd(`DSR_OFF_RESET_CAUSE, 16'hffff, 16'he5ff);
        @(negedge clk);
        chk("internal_por", 32'h0, 32'(por));
        @(posedge clk);
        wr(8'h20, 16'hffff);
        rd(8'h20, 16'hffff, 16'h0000);
        wr(`DSR_OFF_RESET_CAUSE, 16'h0000);
        wr(`DSR_OFF_DS_CONTROL, 16'h8000);
        repeat (4) @(posedge clk);
        rd(`DSR_OFF_DS_CONTROL, 16'h8000, 16'h0000);
        sleep_cmd(1'b0);
        wr(`DSR_OFF_SCRATCH_0, 16'h1234);
        wr(`DSR_OFF_SCRATCH_1, 16'hbeef);
        go_deep();
        chkp(16'h00ff, 16'h00aa);
        fire_ev(5'h10);
        wake_wait();
        rd(`DSR_OFF_DS_CONTROL, 16'hffff, 16'h0001);
        rd(`DSR_OFF_RESET_CAUSE, 16'h0400, 16'h0400);
        rd(`DSR_OFF_WAKE_SOURCE, 16'hffff, 16'h0100);
        rd(`DSR_OFF_PIN_DIRECTION, 16'hffff, 16'hffff);
        rd(`DSR_OFF_SCRATCH_1, 16'hffff, 16'hbeef);
        wr(`DSR_OFF_PIN_DIRECTION, 16'h0000);
        wr(`DSR_OFF_OUTPUT_LATCH, 16'h0f0f);
        chkp(16'h00ff, 16'h00aa);
        wr(`DSR_OFF_RESET_CAUSE, 16'h0000);
        wr(`DSR_OFF_WAKE_SOURCE, 16'h0000);
        wr(`DSR_OFF_DS_CONTROL, 16'h0000);
        chkp(16'hffff, 16'h0f0f);
        go_deep();
        fire_ev(5'h02);
        @(negedge clk);
        chk("deep_sleep_active", 32'h1, 32'(dsa));
        fire_ev(5'h04);
        wake_wait();
        rd(`DSR_OFF_DS_CONTROL, 16'hffff, 16'h0002);
        chkp(16'h0000, 16'h0000);
        rd(`DSR_OFF_SCRATCH_0, 16'hffff, 16'h0000);
        rd(`DSR_OFF_WAKE_SOURCE, 16'hffff, 16'h0008);
        wr(`DSR_OFF_SCRATCH_0, 16'h5a5a);
        go_deep();
        fire_ev(5'h08);
        wake_wait();
        chkp(16'h0000, 16'h0000);
        rd(`DSR_OFF_SCRATCH_0, 16'hffff, 16'h5a5a);
        rd(`DSR_OFF_WAKE_SOURCE, 16'hffff, 16'h0004);
        rd(`DSR_OFF_RESET_CAUSE, 16'h0080, 16'h0080);
        cfg <= 8'hc1;
        @(negedge clk);
        chk("low_power_rc_osc_enable", 32'h0, 32'(low_power_rc_osc_en));
        @(posedge clk);
        go_deep();
        @(negedge clk);
        chk("low_power_rc_osc_enable", 32'h1, 32'(low_power_rc_osc_en));
        chk("secondary_osc_enable", 32'h1, 32'(secondary_osc_en));
        chk("calendar_tick", 32'(secondary_osc_tick), 32'(cal_tick));
        fire_ev(5'h01);
        wake_wait();
        rd(`DSR_OFF_WAKE_SOURCE, 16'hffff, 16'h0090);
        stop_test();
    end
endmodule
